// File: include/uart_fmt_pkg.sv
package uart_fmt_pkg;

    // register indices; byte address is index times four
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER  = 3'h1;
    localparam logic [2:0] IDX_IIR  = 3'h2;
    localparam logic [2:0] IDX_FMT  = 3'h3;
    localparam logic [2:0] IDX_LSR  = 3'h5;

    // field positions of the format register
    localparam int LEN_LSB    = 0;
    localparam int STOP_BIT   = 2;
    localparam int PAR_EN_BIT = 3;
    localparam int SENSE_BIT  = 4;
    localparam int STICK_BIT  = 5;
    localparam int BREAK_BIT  = 6;
    localparam int DIVSEL_BIT = 7;

    // status register positions
    localparam int LSR_READY   = 0;
    localparam int LSR_OVERRUN = 1;
    localparam int LSR_PARITY  = 2;
    localparam int LSR_FRAMING = 3;
    localparam int LSR_HOLD    = 5;
    localparam int LSR_SHIFT   = 6;

    // reset values
    localparam logic [7:0]  FMT_RESET = 8'h00;
    localparam logic [3:0]  IER_RESET = 4'h0;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [7:0]  IIR_NONE  = 8'h01;

    // timing in 16x ticks
    localparam logic [5:0] TICK_BIT     = 6'h10;
    localparam logic [5:0] TICK_HALF    = 6'h08;
    localparam logic [5:0] TICK_STOP1   = 6'h10;
    localparam logic [5:0] TICK_STOP15  = 6'h18;
    localparam logic [5:0] TICK_STOP2   = 6'h20;

    typedef struct packed {
        logic       divisorSelect;
        logic       breakCtl;
        logic       stickParity;
        logic       paritySense;
        logic       parityEnable;
        logic       stopCount;
        logic [1:0] charLen;
    } lineFormat_s;

endpackage

// File: verilog/baud_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

// 16x tick from clk divided by the programmed divisor
module baud_tick_gen #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // divisor control
    input  wire logic [WIDTH-1:0] divisor,
    input  wire logic             reload,
    // tick out
    output var  logic             tick
);

    logic [WIDTH-1:0] count_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (reload) begin
            count_q <= divisor;
            tick    <= 1'b0;
        end else if (divisor == '0) begin
            // zero divisor: generator stands still
            tick    <= 1'b0;
        end else if (count_q <= WIDTH'(1)) begin
            count_q <= divisor;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q - WIDTH'(1);
            tick    <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: verilog/uart_line_format_control.sv
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module uart_line_format_control #(
    parameter int DIV_WIDTH = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // serial line
    input  wire logic        serialIn,
    output var  logic        serial_out
);

    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_START  = 5'b00010,
        TX_DATA   = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP   = 5'b10000
    } txState_e;

    typedef enum logic [4:0] {
        RX_IDLE   = 5'b00001,
        RX_START  = 5'b00010,
        RX_DATA   = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP   = 5'b10000
    } rxState_e;

    uart_fmt_pkg::lineFormat_s fmt_q;
    logic [3:0]           ier_q;
    logic [DIV_WIDTH-1:0] divisor_q;
    logic                 reload_q;
    logic                 tick;
    logic [7:0]           thr_q;
    logic                 holdEmpty_q;
    logic                 shiftEmpty_q;
    logic [7:0]           rbr_q;
    logic                 dataReady_q;
    logic                 overrun_q;
    logic                 parityErr_q;
    logic                 framingErr_q;

    // data-bit mask for the configured length
    function automatic logic [7:0] lenMask(input logic [1:0] len);
        lenMask = 8'hff >> (2'h3 - len);
    endfunction

    // parity bit to send or expect for given data
    function automatic logic parityOf(
        input logic [7:0] data,
        input uart_fmt_pkg::lineFormat_s f
    );
        logic ones;
        ones = ^(data & lenMask(f.charLen));
        if (f.stickParity) begin
            parityOf = ~f.paritySense;
        end else begin
            parityOf = f.paritySense ? ones : ~ones;
        end
    endfunction

    // stop length in ticks
    function automatic logic [5:0] stopTicks(
        input uart_fmt_pkg::lineFormat_s f
    );
        if (!f.stopCount) begin
            stopTicks = uart_fmt_pkg::TICK_STOP1;
        end else if (f.charLen == 2'h0) begin
            stopTicks = uart_fmt_pkg::TICK_STOP15;
        end else begin
            stopTicks = uart_fmt_pkg::TICK_STOP2;
        end
    endfunction

    // ---------------- bus decode ----------------
    logic       reqStart;
    logic       access;
    logic [2:0] index;
    logic       wrByte;
    logic       rdAccess;
    logic       selDiv;

    assign reqStart = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign access   = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign index    = wb_adr_i[4:2];
    assign wrByte   = access & wb_we_i & wb_sel_i[0];
    assign rdAccess = access & ~wb_we_i;
    assign selDiv   = fmt_q.divisorSelect;

    logic wrThr;
    logic wrIer;
    logic wrDivLo;
    logic wrDivHi;
    logic wrFmt;
    logic rdRbr;
    logic rdLsr;

    assign wrThr   = wrByte & (index == uart_fmt_pkg::IDX_DATA) & ~selDiv;
    assign wrIer   = wrByte & (index == uart_fmt_pkg::IDX_IER) & ~selDiv;
    assign wrDivLo = wrByte & (index == uart_fmt_pkg::IDX_DATA) & selDiv;
    assign wrDivHi = wrByte & (index == uart_fmt_pkg::IDX_IER) & selDiv;
    assign wrFmt   = wrByte & (index == uart_fmt_pkg::IDX_FMT);
    assign rdRbr   = rdAccess & (index == uart_fmt_pkg::IDX_DATA) & ~selDiv;
    assign rdLsr   = rdAccess & (index == uart_fmt_pkg::IDX_LSR);

    // one-cycle ack, dropped the cycle after
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= reqStart;
        end
    end

    // read data captured when the request is first seen
    logic [7:0] readByte;
    always_comb begin
        readByte = 8'h00;
        case (index)
            uart_fmt_pkg::IDX_DATA:
                readByte = selDiv ? divisor_q[7:0] : rbr_q;
            uart_fmt_pkg::IDX_IER:
                readByte = selDiv ? divisor_q[15:8] : {4'h0, ier_q};
            uart_fmt_pkg::IDX_IIR:
                readByte = uart_fmt_pkg::IIR_NONE;
            uart_fmt_pkg::IDX_FMT:
                readByte = fmt_q;
            uart_fmt_pkg::IDX_LSR: begin
                readByte[uart_fmt_pkg::LSR_READY]   = dataReady_q;
                readByte[uart_fmt_pkg::LSR_OVERRUN] = overrun_q;
                readByte[uart_fmt_pkg::LSR_PARITY]  = parityErr_q;
                readByte[uart_fmt_pkg::LSR_FRAMING] = framingErr_q;
                readByte[uart_fmt_pkg::LSR_HOLD]    = holdEmpty_q;
                readByte[uart_fmt_pkg::LSR_SHIFT]   = shiftEmpty_q;
            end
            default:
                readByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (reqStart && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, readByte};
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fmt_q <= uart_fmt_pkg::FMT_RESET;
            ier_q <= uart_fmt_pkg::IER_RESET;
        end else begin
            if (wrFmt) begin
                fmt_q <= wb_dat_i[7:0];
            end
            if (wrIer) begin
                ier_q <= wb_dat_i[3:0];
            end
        end
    end

    // divisor latches; a write reloads the counter next cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divisor_q <= uart_fmt_pkg::DIV_RESET;
            reload_q  <= 1'b0;
        end else begin
            if (wrDivLo) begin
                divisor_q[7:0] <= wb_dat_i[7:0];
            end
            if (wrDivHi) begin
                divisor_q[15:8] <= wb_dat_i[7:0];
            end
            reload_q <= wrDivLo | wrDivHi;
        end
    end

    baud_tick_gen #(
        .WIDTH (DIV_WIDTH)
    ) u_baud (
        .clk     (clk),
        .arst_n  (arst_n),
        .divisor (divisor_q),
        .reload  (reload_q),
        .tick    (tick)
    );

    // ---------------- transmitter ----------------
    txState_e   txState_q;
    logic [7:0] txShift_q;
    logic [2:0] txBit_q;
    logic [5:0] txTicks_q;
    logic       txLine;
    logic       txLoad;

    assign txLoad = (txState_q == TX_IDLE) & ~holdEmpty_q;

    // holding register; a new write wins over the transfer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            thr_q       <= 8'h00;
            holdEmpty_q <= 1'b1;
        end else if (wrThr) begin
            thr_q       <= wb_dat_i[7:0];
            holdEmpty_q <= 1'b0;
        end else if (txLoad) begin
            holdEmpty_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txState_q    <= TX_IDLE;
            txShift_q    <= 8'h00;
            txBit_q      <= 3'h0;
            txTicks_q    <= 6'h00;
            shiftEmpty_q <= 1'b1;
        end else begin
            case (txState_q)
                TX_IDLE: begin
                    txTicks_q <= 6'h00;
                    if (txLoad) begin
                        txShift_q    <= thr_q;
                        shiftEmpty_q <= 1'b0;
                        txState_q    <= TX_START;
                    end
                end
                TX_START: begin
                    if (tick) begin
                        if (txTicks_q == uart_fmt_pkg::TICK_BIT - 6'h01) begin
                            txTicks_q <= 6'h00;
                            txBit_q   <= 3'h0;
                            txState_q <= TX_DATA;
                        end else begin
                            txTicks_q <= txTicks_q + 6'h01;
                        end
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        if (txTicks_q == uart_fmt_pkg::TICK_BIT - 6'h01) begin
                            txTicks_q <= 6'h00;
                            if (txBit_q == {1'b1, fmt_q.charLen}) begin
                                txState_q <= fmt_q.parityEnable ?
                                             TX_PARITY : TX_STOP;
                            end else begin
                                txBit_q <= txBit_q + 3'h1;
                            end
                        end else begin
                            txTicks_q <= txTicks_q + 6'h01;
                        end
                    end
                end
                TX_PARITY: begin
                    if (tick) begin
                        if (txTicks_q == uart_fmt_pkg::TICK_BIT - 6'h01) begin
                            txTicks_q <= 6'h00;
                            txState_q <= TX_STOP;
                        end else begin
                            txTicks_q <= txTicks_q + 6'h01;
                        end
                    end
                end
                TX_STOP: begin
                    if (tick) begin
                        if (txTicks_q == stopTicks(fmt_q) - 6'h01) begin
                            txTicks_q    <= 6'h00;
                            shiftEmpty_q <= 1'b1;
                            txState_q    <= TX_IDLE;
                        end else begin
                            txTicks_q <= txTicks_q + 6'h01;
                        end
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                end
            endcase
        end
    end

    // data bits count from index 0 and end at index 4 plus charLen; see compare
    always_comb begin
        case (txState_q)
            TX_START:  txLine = 1'b0;
            TX_DATA:   txLine = txShift_q[txBit_q];
            TX_PARITY: txLine = parityOf(txShift_q, fmt_q);
            default:   txLine = 1'b1;
        endcase
    end

    // break forces the pin only; the shifter runs on beneath it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_out <= 1'b1;
        end else begin
            serial_out <= fmt_q.breakCtl ? 1'b0 : txLine;
        end
    end

    // ---------------- receiver ----------------
    logic       rxMeta_q;
    logic       rxSync_q;
    rxState_e   rxState_q;
    logic [7:0] rxShift_q;
    logic [2:0] rxBit_q;
    logic [5:0] rxTicks_q;
    logic       rxParity_q;
    logic       rxMid;
    logic       rxDone;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
        end else begin
            rxMeta_q <= serialIn;
            rxSync_q <= rxMeta_q;
        end
    end

    assign rxMid  = tick & (rxTicks_q == uart_fmt_pkg::TICK_BIT - 6'h01);
    assign rxDone = (rxState_q == RX_STOP) & rxMid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxState_q  <= RX_IDLE;
            rxShift_q  <= 8'h00;
            rxBit_q    <= 3'h0;
            rxTicks_q  <= 6'h00;
            rxParity_q <= 1'b0;
        end else begin
            if (tick) begin
                rxTicks_q <= rxMid ? 6'h00 : rxTicks_q + 6'h01;
            end
            case (rxState_q)
                RX_IDLE: begin
                    rxTicks_q <= 6'h00;
                    rxShift_q <= 8'h00;
                    if (!rxSync_q) begin
                        rxState_q <= RX_START;
                    end
                end
                RX_START: begin
                    // centre of start bit; a high here is a false start
                    if (tick && rxTicks_q == uart_fmt_pkg::TICK_HALF - 6'h01) begin
                        rxTicks_q <= 6'h00;
                        rxBit_q   <= 3'h0;
                        rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rxMid) begin
                        rxShift_q[rxBit_q] <= rxSync_q;
                        if (rxBit_q == {1'b1, fmt_q.charLen}) begin
                            rxState_q <= fmt_q.parityEnable ?
                                         RX_PARITY : RX_STOP;
                        end else begin
                            rxBit_q <= rxBit_q + 3'h1;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rxMid) begin
                        rxParity_q <= rxSync_q;
                        rxState_q  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // only the first stop bit is sampled
                    if (rxMid) begin
                        rxState_q <= RX_IDLE;
                    end
                end
                default: begin
                    rxState_q <= RX_IDLE;
                end
            endcase
        end
    end

    // receive buffer and status; a new event wins over a read clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rbr_q        <= 8'h00;
            dataReady_q  <= 1'b0;
            overrun_q    <= 1'b0;
            parityErr_q  <= 1'b0;
            framingErr_q <= 1'b0;
        end else if (rxDone) begin
            rbr_q       <= rxShift_q & lenMask(fmt_q.charLen);
            dataReady_q <= 1'b1;
            if (dataReady_q && !rdRbr) begin
                overrun_q <= 1'b1;
            end else if (rdLsr) begin
                overrun_q <= 1'b0;
            end
            if (fmt_q.parityEnable &&
                rxParity_q != parityOf(rxShift_q, fmt_q)) begin
                parityErr_q <= 1'b1;
            end else if (rdLsr) begin
                parityErr_q <= 1'b0;
            end
            if (!rxSync_q) begin
                framingErr_q <= 1'b1;
            end else if (rdLsr) begin
                framingErr_q <= 1'b0;
            end
        end else begin
            if (rdRbr) begin
                dataReady_q <= 1'b0;
            end
            if (rdLsr) begin
                overrun_q    <= 1'b0;
                parityErr_q  <= 1'b0;
                framingErr_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: sim/uart_line_format_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uart_line_format_control_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // serial line
    input wire logic        serialIn,
    input wire logic        serial_out
);
    logic [7:0]  fmtQ;
    logic [15:0] divQ;
    logic [3:0]  ierQ;
    logic        divSetQ;
    logic        wr;
    logic        rd;
    logic [2:0]  idx;
    assign idx = wb_adr_i[4:2];
    assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign rd = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // shadow of the host's register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fmtQ    <= uart_fmt_pkg::FMT_RESET;
            divQ    <= uart_fmt_pkg::DIV_RESET;
            ierQ    <= uart_fmt_pkg::IER_RESET;
            divSetQ <= 1'b0;
        end else if (wr) begin
            if (idx == uart_fmt_pkg::IDX_FMT) fmtQ <= wb_dat_i[7:0];
            if (idx == uart_fmt_pkg::IDX_DATA && fmtQ[7]) begin
                divQ[7:0] <= wb_dat_i[7:0];
                divSetQ   <= 1'b1;
            end
            if (idx == uart_fmt_pkg::IDX_IER && fmtQ[7]) begin
                divQ[15:8] <= wb_dat_i[7:0];
                divSetQ    <= 1'b1;
            end
            if (idx == uart_fmt_pkg::IDX_IER && !fmtQ[7]) ierQ <= wb_dat_i[3:0];
        end
    end
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    upper_zero_a: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    fmt_readback_a: assert property (
        rd && idx == uart_fmt_pkg::IDX_FMT |-> wb_dat_o[7:0] == fmtQ)
        else $error("format register readback wrong");
    div_low_read_a: assert property (
        rd && fmtQ[7] && idx == 3'h0 |-> wb_dat_o[7:0] == divQ[7:0])
        else $error("divisor low readback wrong");
    div_high_read_a: assert property (
        rd && fmtQ[7] && idx == 3'h1 |-> wb_dat_o[7:0] == divQ[15:8])
        else $error("divisor high readback wrong");
    ier_read_a: assert property (
        rd && !fmtQ[7] && idx == 3'h1 |-> wb_dat_o[7:0] == {4'h0, ierQ})
        else $error("interrupt enable readback wrong");
    break_hold_a: assert property (
        fmtQ[6] && $past(fmtQ[6]) |-> !serial_out)
        else $error("serial output not held low in break");
    stopped_idle_a: assert property (
        !divSetQ && !fmtQ[6] && !$past(fmtQ[6]) |-> serial_out)
        else $error("serial output moved with divisor unset");
endmodule
bind uart_line_format_control uart_line_format_control_monitor i_mon (
    .clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .serialIn, .serial_out);
`default_nettype wire

// File: sim/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    // clock
    input  wire logic clk,
    // line
    input  wire logic lineIn,
    output var  logic lineOut
);
    initial lineOut = 1'b1;
    // samples n bits mid-bit; gap runs to the next start edge
    task automatic grab(input int n, input int bc, output logic [11:0] bits,
                        output int gap);
        int t;
        t = 0;
        bits = 12'hfff;
        while (lineIn !== 1'b0 && t < 4000) begin
            @(posedge clk);
            t++;
        end
        repeat (bc / 2) @(posedge clk);
        gap = bc / 2;
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (bc) @(posedge clk);
            if (i > 0) gap += bc;
            bits[i] = lineIn;
        end
        do begin
            @(posedge clk);
            gap++;
        end while (lineIn !== 1'b0 && gap < 4000);
    endtask
    // lsb first, line back to mark level afterwards
    task automatic send(input logic [31:0] bits, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            lineOut <= bits[i];
            repeat (bc) @(posedge clk);
        end
        lineOut <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: sim/uart_line_format_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_line_format_control_tb;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [4:0]  wbAdr = 5'h00;
    logic [3:0]  wbSel = 4'h1;
    logic [31:0] wbDat = 32'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        rxLine;
    logic        txLine;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [15:0] divTab [4] = '{16'h000c, 16'h0900, 16'h0014, 16'h0f00};
    logic [7:0]  rowFmt [7] = '{8'h00, 8'h0c, 8'h1d, 8'h2a, 8'h3f, 8'h23, 8'h1b};
    logic [7:0]  rowDat [7] = '{8'hb5, 8'he3, 8'h7a, 8'h00, 8'hff, 8'h5a, 8'h81};
    int          rowDiv [7] = '{1, 1, 2, 1, 1, 1, 1};
    int          rowGap [7] = '{113, 137, 320, 161, 193, 161, 177};
    always #10 clk = ~clk;
    uart_line_format_control #(.DIV_WIDTH(16)) i_dut (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .serialIn(rxLine),
        .serial_out(txLine));
    serial_peer i_peer (.clk(clk), .lineIn(txLine), .lineOut(rxLine));
    task automatic check(input string w, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", w, e, s);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic bus(input logic we, input logic [2:0] i,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {i, 2'b00};
        wbDat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n == 50) check("ack", 32'(wbAck), 32'h1);
        q = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, i, d, q);
    endtask
    task automatic rdc(input string w, input logic [2:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, i, 8'h00, q);
        check(w, 32'(q), 32'(e));
    endtask
    task automatic wait_idle;
        logic [7:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, 3'h5, 8'h00, q);
            n++;
        end while (q[6] !== 1'b1 && n < 300);
        check("shift empty", 32'(q[6]), 32'h1);
    endtask
    // expected line bits: start, data lsb first, parity, stop
    function automatic logic [11:0] frame(input logic [7:0] f, d, output int m);
        int n;
        logic par;
        n = 5 + f[1:0];
        par = 1'b0;
        frame = 12'hffe;
        for (int i = 0; i < n; i++) begin
            frame[i+1] = d[i];
            par ^= d[i];
        end
        m = n + 1;
        if (f[3]) begin
            frame[m] = f[5] ? !f[4] : (f[4] ? par : !par);
            m++;
        end
        m++;
    endfunction
    initial begin
        logic [11:0] exp;
        logic [11:0] got;
        logic [31:0] lo;
        int m;
        int gap;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check("idle line", 32'(txLine), 32'h1);
        rdc("format reset", 3'h3, 8'h00);
        rdc("status reset", 3'h5, 8'h60);
        rdc("ident", 3'h2, 8'h01);
        wr(3'h7, 8'hff);
        rdc("unmapped", 3'h7, 8'h00);
        wr(3'h1, 8'h0f);
        wbSel <= 4'h0;
        wr(3'h3, 8'h55);
        wbSel <= 4'h1;
        rdc("sel ignored", 3'h3, 8'h00);
        wr(3'h3, 8'h80);
        foreach (divTab[k]) begin
            wr(3'h0, divTab[k][7:0]);
            wr(3'h1, divTab[k][15:8]);
            rdc("div low", 3'h0, divTab[k][7:0]);
            rdc("div high", 3'h1, divTab[k][15:8]);
        end
        wr(3'h3, 8'h00);
        rdc("ier", 3'h1, 8'h0f);
        for (int r = 0; r < 7; r++) begin
            exp = frame(rowFmt[r], rowDat[r], m);
            wr(3'h3, 8'h80);
            wr(3'h0, rowDiv[r][7:0]);
            wr(3'h1, 8'h00);
            wr(3'h3, rowFmt[r]);
            fork
                begin
                    wr(3'h0, rowDat[r]);
                    wr(3'h0, rowDat[r]);
                end
                i_peer.grab(m, 16 * rowDiv[r], got, gap);
            join
            check("tx frame", 32'(got), 32'(exp));
            check("tx gap", gap, rowGap[r]);
            wait_idle();
            lo = 32'(exp) & ((32'h1 << m) - 32'h1);
            i_peer.send(lo | (lo << m), 2 * m, 16 * rowDiv[r]);
            repeat (4) @(posedge clk);
            rdc("rx status", 3'h5, 8'h63);
            rdc("rx data", 3'h0, rowDat[r] & (8'hff >> (2'h3 - rowFmt[r][1:0])));
        end
        exp = frame(8'h1b, 8'h81, m);
        i_peer.send(32'(exp ^ 12'h200), m, 16);
        repeat (4) @(posedge clk);
        rdc("parity error", 3'h5, 8'h65);
        rdc("error cleared", 3'h5, 8'h61);
        rdc("rx data", 3'h0, 8'h81);
        i_peer.send(32'(exp ^ 12'h400), m, 16);
        repeat (4) @(posedge clk);
        rdc("framing error", 3'h5, 8'h69);
        rdc("rx data", 3'h0, 8'h81);
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h5b);
        rdc("busy in break", 3'h5, 8'h20);
        check("break level", 32'(txLine), 32'h0);
        wait_idle();
        check("break held", 32'(txLine), 32'h0);
        wr(3'h3, 8'h1b);
        repeat (2) @(posedge clk);
        check("break released", 32'(txLine), 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
